//--- logic/fps_defines.svh
// Purpose: constants of the frequency protection block
// Assumes: 25 MHz system clock, AHB-Lite register access
// Notes:   byte offsets within the block, low eight address bits
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FPS_CLK_HZ        25000000
`define FPS_TICK_MS       1
`define FPS_TICK_CYCLES   (`FPS_CLK_HZ / 1000 * `FPS_TICK_MS)
`define FPS_FORCE_MIN     5
`define FPS_FORCE_TICKS   (`FPS_FORCE_MIN * 60 * 1000 / `FPS_TICK_MS)
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FPS_A_CTRL        8'h00
`define FPS_A_KEY         8'h04
`define FPS_A_LVBLK       8'h08
`define FPS_A_STATUS      8'h0C
`define FPS_A_FORCE       8'h10
`define FPS_A_IRQSTS      8'h14
`define FPS_A_IRQEN       8'h18
`define FPS_A_IRQCLR      8'h1C
`define FPS_A_CNTCLR      8'h20
`define FPS_A_FREQ        8'h24
`define FPS_A_FLTSEL      8'h28
`define FPS_A_FLTDATE     8'h2C
`define FPS_A_FLTTIME     8'h30
`define FPS_A_FLTINFO     8'h34
`define FPS_A_CNT_HI      4'h4
`define FPS_A_SET_HI      2'b10
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define FPS_CTRL_FORCE    0
`define FPS_CTRL_SRC      3:1
`define FPS_CTRL_MAN      5:4
`define FPS_CTRL_ALT      7:6
`define FPS_CTRL_IDX      11:8
`define FPS_CTRL_MASK     32'h0000_0FFF
`define FPS_SET_PICK      15:0
`define FPS_SET_DLY       30:16
`define FPS_SET_OVER      31
`define FPS_SET_RST       32'h0064_0000
`define FPS_LVBLK_RST     8'h0A
`define FPS_PCT_FULL      7'h64
`define FPS_PCT_STEP      17'h00064
`endif

//--- logic/fps_pkg.sv
// Purpose: types of the frequency protection block
// Assumes: nothing
// Notes:   shared by the stage and the top module
package fps_pkg;
	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FPS_IDLE = 2'b00,
		FPS_RUN  = 2'b01,
		FPS_TRIP = 2'b10
	} fps_stage_state_type;
	typedef enum logic [2:0] {
		FPS_SRC_NONE  = 3'b000,
		FPS_SRC_DIG   = 3'b001,
		FPS_SRC_SOFTI = 3'b010,
		FPS_SRC_LAMP  = 3'b011,
		FPS_SRC_SOFTO = 3'b100
	} fps_src_type;
	// ----------------------------------------------------------------
	// structures
	// ----------------------------------------------------------------
	typedef struct packed {
		fps_stage_state_type state;
		logic                start;
		logic                trip;
		logic                blk;
		logic                latch;
		logic [14:0]         elapsed;
		logic [16:0]         acc;
		logic [6:0]          pct;
	} fps_stage_type;
	typedef struct packed {
		logic [31:0] date;
		logic [31:0] tod;
		logic [15:0] freq;
		logic [6:0]  pct;
		logic [1:0]  grp;
		logic [1:0]  stage;
	} fps_fault_type;
endpackage : fps_pkg

//--- logic/fps_stage.sv
// Purpose: one definite-time frequency stage
// Assumes: settings stable while applied, one tick per millisecond
// Notes:   outputs come straight from the state register
`timescale 1ns/1ns
`default_nettype none
`include "fps_defines.svh"
module fps_stage (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        tick_i,
	input  wire logic [15:0] freq_i,
	input  wire logic [15:0] pickup_i,
	input  wire logic [14:0] delay_i,
	input  wire logic        over_i,
	input  wire logic        lv_low_i,
	input  wire logic        force_i,
	input  wire logic        force_start_i,
	input  wire logic        force_trip_i,
	output logic             start_o,
	output logic             trip_o,
	output logic             blocked_o,
	output logic [6:0]       pct_o
);
	import fps_pkg::*;
	fps_stage_type q_reg;
	fps_stage_type q_next;
	logic          cond;
	logic          blocked;
	logic [16:0]   acc_sum;
	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		q_next  = q_reg;
		cond    = over_i ? (freq_i > pickup_i) : (freq_i < pickup_i);
		acc_sum = q_reg.acc + `FPS_PCT_STEP;
		if (!over_i && lv_low_i) begin
			q_next.latch = 1'b1;
		end else if (freq_i >= pickup_i) begin
			q_next.latch = 1'b0;
		end
		blocked      = !over_i && (lv_low_i || q_reg.latch);
		q_next.blk   = blocked;
		if (force_i) begin
			q_next.start   = force_start_i;
			q_next.trip    = force_trip_i;
			q_next.state   = FPS_IDLE;
			q_next.elapsed = 15'h0000;
		end else begin
			case (q_reg.state)
				FPS_IDLE: begin
					q_next.start = 1'b0;
					q_next.trip  = 1'b0;
					if (cond && !blocked) begin
						q_next.state   = FPS_RUN;
						q_next.start   = 1'b1;
						q_next.elapsed = 15'h0000;
						q_next.acc     = 17'h00000;
						q_next.pct     = 7'h00;
					end
				end
				FPS_RUN: begin
					if (!cond || blocked) begin
						q_next.state   = FPS_IDLE;
						q_next.start   = 1'b0;
						q_next.elapsed = 15'h0000;
					end else if (q_reg.elapsed >= delay_i) begin
						q_next.state = FPS_TRIP;
						q_next.trip  = 1'b1;
						q_next.pct   = `FPS_PCT_FULL;
					end else if (tick_i) begin
						q_next.elapsed = q_reg.elapsed + 15'h0001;
						if (acc_sum >= {2'b00, delay_i}) begin
							q_next.acc = acc_sum - {2'b00, delay_i};
							if (q_reg.pct < `FPS_PCT_FULL - 7'h01) begin
								q_next.pct = q_reg.pct + 7'h01;
							end
						end else begin
							q_next.acc = acc_sum;
						end
					end
				end
				FPS_TRIP: begin
					if (!cond || blocked) begin
						q_next.state = FPS_IDLE;
						q_next.start = 1'b0;
						q_next.trip  = 1'b0;
					end
				end
				default: begin
					q_next.state = FPS_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end
	assign start_o   = q_reg.start;
	assign trip_o    = q_reg.trip;
	assign blocked_o = q_reg.blk;
	assign pct_o     = q_reg.pct;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_trip_needs_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(trip_o && !$past(force_i)) |-> start_o)
		else $error("trip without start");
	a_trip_after_delay: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		($rose(trip_o) && !$past(force_i)) |-> $past(q_reg.elapsed >= delay_i))
		else $error("trip before delay");
	a_block_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(blocked && !force_i) |=> (!start_o && !trip_o))
		else $error("blocked stage active");
	a_release_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(!cond && !force_i && q_reg.state == FPS_RUN) |=> (!start_o && !trip_o))
		else $error("release did not clear");
endmodule : fps_stage
`default_nettype wire

//--- logic/fps_top.sv
// Purpose: four frequency protection stages behind an AHB-Lite slave
// Assumes: FREQ_I in 0.01 Hz, line voltages in percent of nominal
// Notes:   zero wait states, OKAY answers, word accesses
`timescale 1ns/1ns
`default_nettype none
`include "fps_defines.svh"
module fps_top #(
	parameter int unsigned TICK_CYCLES = `FPS_TICK_CYCLES,
	parameter int unsigned FORCE_TICKS = `FPS_FORCE_TICKS,
	parameter logic [31:0] PASS_KEY    = 32'h5A5A_0001 // arbitrary value
) (
	input  wire logic        CLK_I,
	input  wire logic        ARST_N_I,
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic [31:0]      HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	input  wire logic [15:0] FREQ_I,
	input  wire logic [1:0]  VOLT_PRESENT_I,
	input  wire logic [7:0]  U12_PCT_I,
	input  wire logic [7:0]  U23_PCT_I,
	input  wire logic [7:0]  U31_PCT_I,
	input  wire logic [15:0] DIG_IN_I,
	input  wire logic [15:0] SOFT_IN_I,
	input  wire logic [15:0] LAMP_I,
	input  wire logic [15:0] SOFT_OUT_I,
	input  wire logic [31:0] DATE_I,
	input  wire logic [31:0] TIME_MS_I,
	output logic [3:0]       START_O,
	output logic [3:0]       TRIP_O,
	output logic [3:0]       BLOCKED_O,
	output logic             IRQ_O
);
	import fps_pkg::*;
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int FW = $clog2(FORCE_TICKS + 1);
	typedef struct packed {
		logic [15:0][31:0] set;
		logic [11:0]       ctrl;
		logic [7:0]        lvblk;
		logic              unlocked;
		logic [7:0]        force_st;
		logic [8:0]        irq_sts;
		logic [8:0]        irq_en;
		logic              irq;
		logic [3:0][15:0]  st_cnt;
		logic [3:0][15:0]  tr_cnt;
		fps_fault_type [7:0] flt;
		logic [2:0]        wptr;
		logic [2:0]        flt_sel;
		logic [31:0]       rdata;
		logic              ready;
		logic              wr_pend;
		logic [7:0]        wr_addr;
		logic [TW-1:0]     tick_cnt;
		logic              tick;
		logic [FW-1:0]     force_cnt;
		logic [15:0]       freq;
		logic [15:0]       freq_prev;
		logic              adapted;
		logic [1:0]        grp;
		logic [3:0]        st_prev;
		logic [3:0]        tr_prev;
		logic              lv_low;
	} fps_top_type;
	fps_top_type   q_reg;
	fps_top_type   q_next;
	logic [3:0]    st_w;
	logic [3:0]    tr_w;
	logic [3:0]    blk_w;
	logic [3:0][6:0] pct_w;
	logic [31:0]   rd;
	logic [31:0]   wd;
	logic          wr;
	logic [3:0]    st_rise;
	logic [3:0]    tr_rise;
	logic [3:0]    rec;
	logic [15:0]   sig_vec;
	logic [7:0]    umax;
	logic [2:0]    ridx;
	logic [1:0]    rstg;
	logic          force_on;
	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic fps_set_hit(input logic [7:0] a);
		fps_set_hit = (a[7:6] == `FPS_A_SET_HI);
	endfunction : fps_set_hit
	function automatic logic fps_cnt_hit(input logic [7:0] a);
		fps_cnt_hit = (a[7:4] == `FPS_A_CNT_HI);
	endfunction : fps_cnt_hit
	// ----------------------------------------------------------------
	// stages
	// ----------------------------------------------------------------
	generate
		for (genvar s = 0; s < 4; s++) begin : g_stage
			localparam logic [1:0] SI = 2'(s);
			logic [31:0] cfg;
			assign cfg = q_reg.set[{SI, q_reg.grp}];
			fps_stage u_stage (
				.clk_i         (CLK_I),
				.arst_n_i      (ARST_N_I),
				.tick_i        (q_reg.tick),
				.freq_i        (q_reg.freq),
				.pickup_i      (cfg[`FPS_SET_PICK]),
				.delay_i       (cfg[`FPS_SET_DLY]),
				.over_i        ((s < 2) && cfg[`FPS_SET_OVER]),
				.lv_low_i      (q_reg.lv_low),
				.force_i       (force_on),
				.force_start_i (q_reg.force_st[s]),
				.force_trip_i  (q_reg.force_st[s + 4]),
				.start_o       (st_w[s]),
				.trip_o        (tr_w[s]),
				.blocked_o     (blk_w[s]),
				.pct_o         (pct_w[s])
			);
		end
	endgenerate
	assign force_on = q_reg.ctrl[`FPS_CTRL_FORCE];
	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		q_next  = q_reg;
		wr      = q_reg.wr_pend;
		wd      = HWDATA_I;
		st_rise = st_w & ~q_reg.st_prev;
		tr_rise = tr_w & ~q_reg.tr_prev;
		rec     = force_on ? 4'h0 : (tr_rise | (q_reg.st_prev & ~st_w & ~q_reg.tr_prev));
		ridx    = q_reg.wptr - 3'h1 - q_reg.flt_sel;
		rstg    = 2'h0;
		umax    = U12_PCT_I;
		sig_vec = 16'h0000;
		rd      = 32'h0000_0000;
		// millisecond tick
		q_next.tick = 1'b0;
		if (q_reg.tick_cnt == TW'(TICK_CYCLES - 1)) begin
			q_next.tick_cnt = '0;
			q_next.tick     = 1'b1;
		end else begin
			q_next.tick_cnt = q_reg.tick_cnt + TW'(1);
		end
		// measured or adapted frequency
		if (|VOLT_PRESENT_I) begin
			q_next.freq = FREQ_I;
		end
		q_next.adapted   = ~|VOLT_PRESENT_I;
		q_next.freq_prev = q_reg.freq;
		if (U23_PCT_I > umax) begin
			umax = U23_PCT_I;
		end
		if (U31_PCT_I > umax) begin
			umax = U31_PCT_I;
		end
		q_next.lv_low = umax < q_reg.lvblk;
		// group selection
		case (fps_src_type'(q_reg.ctrl[`FPS_CTRL_SRC]))
			FPS_SRC_DIG:   sig_vec = DIG_IN_I;
			FPS_SRC_SOFTI: sig_vec = SOFT_IN_I;
			FPS_SRC_LAMP:  sig_vec = LAMP_I;
			FPS_SRC_SOFTO: sig_vec = SOFT_OUT_I;
			default:       sig_vec = 16'h0000;
		endcase
		q_next.grp = sig_vec[q_reg.ctrl[`FPS_CTRL_IDX]] ? q_reg.ctrl[`FPS_CTRL_ALT] :
			q_reg.ctrl[`FPS_CTRL_MAN];
		// force timeout
		if (!force_on) begin
			q_next.force_cnt = '0;
		end else if (q_reg.tick) begin
			if (q_reg.force_cnt == FW'(FORCE_TICKS - 1)) begin
				q_next.ctrl[`FPS_CTRL_FORCE] = 1'b0;
				q_next.force_cnt             = '0;
			end else begin
				q_next.force_cnt = q_reg.force_cnt + FW'(1);
			end
		end
		// counters and fault record
		q_next.st_prev = st_w;
		q_next.tr_prev = tr_w;
		for (int s = 0; s < 4; s++) begin
			if (wr && q_reg.wr_addr == `FPS_A_CNTCLR && wd[s]) begin
				q_next.st_cnt[s] = 16'h0000;
			end
			if (wr && q_reg.wr_addr == `FPS_A_CNTCLR && wd[s + 4]) begin
				q_next.tr_cnt[s] = 16'h0000;
			end
			if (st_rise[s]) begin
				q_next.st_cnt[s] = q_next.st_cnt[s] + 16'h0001;
			end
			if (tr_rise[s]) begin
				q_next.tr_cnt[s] = q_next.tr_cnt[s] + 16'h0001;
			end
		end
		for (int s = 3; s >= 0; s--) begin
			if (rec[s]) begin
				rstg = 2'(s);
			end
		end
		if (|rec) begin
			q_next.flt[q_reg.wptr] = '{date: DATE_I, tod: TIME_MS_I, freq: q_reg.freq_prev,
				pct: pct_w[rstg], grp: q_reg.grp, stage: rstg};
			q_next.wptr = q_reg.wptr + 3'h1;
		end
		// interrupt status, set wins over clear
		if (wr && q_reg.wr_addr == `FPS_A_IRQCLR) begin
			q_next.irq_sts = q_reg.irq_sts & ~wd[8:0];
		end
		q_next.irq_sts = q_next.irq_sts | {|rec, tr_rise, st_rise};
		// register writes
		if (wr) begin
			if (q_reg.wr_addr == `FPS_A_KEY) begin
				q_next.unlocked = (wd == PASS_KEY);
			end
			if (q_reg.unlocked) begin
				if (q_reg.wr_addr == `FPS_A_CTRL) begin
					q_next.ctrl = wd[11:0];
				end
				if (q_reg.wr_addr == `FPS_A_LVBLK) begin
					q_next.lvblk = wd[7:0];
				end
				if (fps_set_hit(q_reg.wr_addr)) begin
					q_next.set[q_reg.wr_addr[5:2]] = wd;
				end
			end
			if (q_reg.wr_addr == `FPS_A_FORCE && force_on) begin
				q_next.force_st = wd[7:0];
			end
			if (q_reg.wr_addr == `FPS_A_IRQEN) begin
				q_next.irq_en = wd[8:0];
			end
			if (q_reg.wr_addr == `FPS_A_FLTSEL) begin
				q_next.flt_sel = wd[2:0];
			end
		end
		q_next.irq = |(q_next.irq_sts & q_next.irq_en);
		// read mux
		case (HADDR_I[7:0])
			`FPS_A_CTRL:    rd = {20'h00000, q_reg.ctrl};
			`FPS_A_KEY:     rd = {31'h0000_0000, q_reg.unlocked};
			`FPS_A_LVBLK:   rd = {24'h000000, q_reg.lvblk};
			`FPS_A_STATUS:  rd = {15'h0000, q_reg.unlocked, q_reg.adapted, force_on,
				q_reg.grp, tr_w, st_w, blk_w};
			`FPS_A_FORCE:   rd = {24'h000000, q_reg.force_st};
			`FPS_A_IRQSTS:  rd = {23'h000000, q_reg.irq_sts};
			`FPS_A_IRQEN:   rd = {23'h000000, q_reg.irq_en};
			`FPS_A_FREQ:    rd = {16'h0000, q_reg.freq};
			`FPS_A_FLTSEL:  rd = {29'h0000_0000, q_reg.flt_sel};
			`FPS_A_FLTDATE: rd = q_reg.flt[ridx].date;
			`FPS_A_FLTTIME: rd = q_reg.flt[ridx].tod;
			`FPS_A_FLTINFO: rd = {4'h0, q_reg.flt[ridx].stage, q_reg.flt[ridx].grp,
				1'b0, q_reg.flt[ridx].pct, q_reg.flt[ridx].freq};
			default: begin
				if (fps_set_hit(HADDR_I[7:0])) begin
					rd = q_reg.set[HADDR_I[5:2]];
				end else if (fps_cnt_hit(HADDR_I[7:0])) begin
					rd = {q_reg.tr_cnt[HADDR_I[3:2]], q_reg.st_cnt[HADDR_I[3:2]]};
				end
			end
		endcase
		if (HADDR_I[31:8] != 24'h000000) begin
			rd = 32'h0000_0000;
		end
		// bus address phase
		q_next.ready   = 1'b1;
		q_next.wr_pend = 1'b0;
		if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
			q_next.wr_pend = HWRITE_I && (HADDR_I[31:8] == 24'h000000);
			q_next.wr_addr = HADDR_I[7:0];
			if (!HWRITE_I) begin
				q_next.rdata = rd;
			end
		end
	end
	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			q_reg       <= '0;
			q_reg.set   <= {16{`FPS_SET_RST}};
			q_reg.lvblk <= `FPS_LVBLK_RST;
		end else begin
			q_reg <= q_next;
		end
	end
	assign HRDATA_O    = q_reg.rdata;
	assign HREADYOUT_O = q_reg.ready;
	assign HRESP_O     = 1'b0;
	assign START_O     = st_w;
	assign TRIP_O      = tr_w;
	assign BLOCKED_O   = blk_w;
	assign IRQ_O       = q_reg.irq;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I);
	a_freq_measured: assert property (|VOLT_PRESENT_I |=> q_reg.freq == $past(FREQ_I))
		else $error("measured frequency not taken");
	a_freq_adapted: assert property (!(|VOLT_PRESENT_I) |=> $stable(q_reg.freq))
		else $error("adapted frequency changed");
	a_set_locked: assert property (!q_reg.unlocked |=> $stable(q_reg.set) && $stable(q_reg.lvblk))
		else $error("setting changed while locked");
	a_force_reject: assert property ((wr && q_reg.wr_addr == `FPS_A_FORCE && !force_on)
		|=> $stable(q_reg.force_st))
		else $error("force write taken without force");
	a_force_timeout: assert property ((force_on && q_reg.tick &&
		q_reg.force_cnt == FW'(FORCE_TICKS - 1) && !wr) |=> !force_on)
		else $error("force not cleared at timeout");
	a_start_count: assert property ((st_rise[0] && !wr) |=>
		q_reg.st_cnt[0] == $past(q_reg.st_cnt[0]) + 16'h0001)
		else $error("start count missed");
	a_fault_ptr: assert property (|rec |=> q_reg.wptr == $past(q_reg.wptr) + 3'h1)
		else $error("fault not recorded");
	a_irq_level: assert property (##1 IRQ_O == |(q_reg.irq_sts & q_reg.irq_en))
		else $error("interrupt level wrong");
	a_bus_okay: assert property ($past(ARST_N_I) |-> HREADYOUT_O && !HRESP_O)
		else $error("bus answer not ready okay");
endmodule : fps_top
`default_nettype wire

//--- tb/fps_front_model.sv
// Purpose: model of the voltage measuring front end
// Assumes: bench sets frequency, line voltage and presence
// Notes:   frequency line toggles while no voltage is present
`timescale 1ns/1ns
`default_nettype none
module fps_front_model (
	input  wire logic [0:0]  clk_i,
	input  wire logic [15:0] f_i,
	input  wire logic [7:0]  u_i,
	input  wire logic [1:0]  on_i,
	output logic      [15:0] freq_o,
	output logic      [1:0]  present_o,
	output logic      [7:0]  u12_o,
	output logic      [7:0]  u23_o,
	output logic      [7:0]  u31_o
);
	always @(posedge clk_i) begin
		present_o <= on_i;
		u12_o     <= u_i;
		u23_o     <= u_i >> 1;
		u31_o     <= u_i >> 2;
		freq_o    <= (|on_i) ? f_i : ~freq_o;
	end
endmodule : fps_front_model
`default_nettype wire

//--- tb/test_fps_top.sv
// Purpose: self-checking bench of the frequency protection block
// Assumes: tick shortened to 4 cycles, force timeout to 10 ticks
// Notes:   dip depths drawn from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module test_fps_top;
	logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, irq;
	logic [1:0]  htrans = 2'h0, on = 2'h3, pres;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_v, date = '0;
	logic [15:0] f = 16'h1388, fv, freq, dig = '0, sin, lamp, sout;
	logic [7:0]  u = 8'h64, u12, u23, u31;
	logic [3:0]  st, tr, bl;
	int          err_total = 0, cmp_count = 0;
	always #20 clk = ~clk;
	always @(posedge clk) date <= date + 32'h1;
	fps_front_model i_fps_front_model (.clk_i(clk), .f_i(f), .u_i(u), .on_i(on), .freq_o(freq),
		.present_o(pres), .u12_o(u12), .u23_o(u23), .u31_o(u31));
	fps_top #(.TICK_CYCLES(4), .FORCE_TICKS(10)) i_fps_top (.CLK_I(clk), .ARST_N_I(rst_n),
		.HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
		.HRESP_O(hresp), .FREQ_I(freq), .VOLT_PRESENT_I(pres), .U12_PCT_I(u12), .U23_PCT_I(u23),
		.U31_PCT_I(u31), .DIG_IN_I(dig), .SOFT_IN_I(sin), .LAMP_I(lamp), .SOFT_OUT_I(sout),
		.DATE_I(date), .TIME_MS_I(date), .START_O(st), .TRIP_O(tr), .BLOCKED_O(bl), .IRQ_O(irq));
	// --------
	// helpers
	// --------
	function logic [31:0] sa(input int s, input int g);
		return 32'h80 + 32'(4 * (4 * s + g));
	endfunction : sa
	function logic [31:0] sw(input logic [15:0] p, input logic [14:0] d, input logic o);
		return {o, d, p};
	endfunction : sw
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd_v = hrdata;
	endtask : bus
	task rd(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, '0);
		chk(rd_v, e);
	endtask : rd
	task step(input int n);
		repeat (n) @(negedge clk);
	endtask : step
	task note(input string s);
		$display("test %s done, mismatches %0d", s, err_total);
	endtask : note
	task dip;
		fv = 16'h1324 - 16'(1 + $urandom % 400);
		@(posedge clk) f <= fv;
	endtask : dip
	task end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		end_of_test();
	end
	// --------
	// main sequence
	// --------
	initial begin
		void'($urandom(32'h1BB947F7));
		sin = 16'($urandom);
		lamp = 16'($urandom);
		sout = 16'($urandom);
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(32'h08, 32'h0A);
		rd(sa(3, 3), 32'h0064_0000);
		rd(32'hFC, 32'h0);
		bus(1'b1, 32'h08, 32'h14);
		rd(32'h08, 32'h0A);
		bus(1'b1, 32'h04, 32'h5A5A_0001);
		bus(1'b1, sa(0, 0), sw(16'h1324, 15'h3, 1'b0));
		bus(1'b1, sa(1, 0), sw(16'h13EC, 15'h3, 1'b1));
		bus(1'b1, 32'h18, 32'h1FF);
		bus(1'b1, 32'h10, 32'h0F);
		rd(32'h10, 32'h0);
		rd(32'h0C, 32'h0001_0000);
		note("setup");
		repeat (3) begin
			dip();
			step(4);
			chk({tr, st}, 8'h01);
			@(posedge clk) f <= 16'h1388;
			step(4);
			chk({tr, st}, 8'h00);
		end
		dip();
		step(8);
		chk({tr, st}, 8'h01);
		step(16);
		chk({tr, st}, 8'h11);
		rd(32'h34, {4'h0, 2'h0, 2'h0, 1'b0, 7'h64, fv});
		chk(irq, 1'b1);
		rd(32'h40, 32'h0001_0004);
		bus(1'b1, 32'h20, 32'h11);
		rd(32'h40, 32'h0);
		bus(1'b1, 32'h1C, 32'h1FF);
		rd(32'h14, 32'h0);
		step(2);
		chk(irq, 1'b0);
		note("timing");
		@(posedge clk) f <= 16'h13EC + 16'(1 + $urandom % 400);
		step(4);
		chk(st, 4'h2);
		@(posedge clk) u <= 8'h05;
		dip();
		step(6);
		chk({st, bl}, 8'h0D);
		@(posedge clk) u <= 8'h64;
		step(6);
		chk({st, bl}, 8'h01);
		@(posedge clk) f <= 16'h1388;
		step(4);
		dip();
		step(4);
		chk(st, 4'h1);
		@(posedge clk) f <= 16'h1388;
		@(posedge clk) on <= 2'h0;
		step(6);
		rd(32'h24, 32'h1388);
		chk(st, 4'h0);
		@(posedge clk) on <= 2'h2;
		f <= 16'h1390;
		step(4);
		rd(32'h24, 32'h1390);
		@(posedge clk) f <= 16'h1388;
		note("voltage");
		bus(1'b1, sa(0, 1), sw(16'h13EC, 15'h3, 1'b0));
		bus(1'b1, 32'h00, 32'h10);
		step(4);
		chk(st, 4'h1);
		@(posedge clk) dig <= 16'h0008;
		bus(1'b1, 32'h00, 32'h312);
		step(4);
		chk(st, 4'h0);
		bus(1'b1, 32'h00, 32'h313);
		bus(1'b1, 32'h10, 32'h22);
		step(3);
		chk({tr, st}, 8'h22);
		step(60);
		bus(1'b0, 32'h0C, '0);
		chk(rd_v[14], 1'b0);
		note("groups");
		end_of_test();
	end
endmodule : test_fps_top
`default_nettype wire
